// File: dv/see_master.sv
// Two-wire bus master model that drives the serial clock.
`timescale 1ns/1ns
`default_nettype none
module see_master (
   input wire logic clk_i, // Core clock, pacing only.
   input wire logic sda_i, // Resolved data wire.
   output logic scl_o, // Serial clock, high when idle.
   output logic sda_oe_o // High pulls the data wire low.
);
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   task automatic w(input int n);
      repeat (n) @(negedge clk_i);
   endtask : w
   // Low 5 cycles, high 3: a 320 ns bit. Data moves two cycles into the
   // low phase; the slave's ack release lands before the clock rises.
   task automatic bit_io(input logic v, output logic r);
      w(2);
      sda_oe_o = ~v;
      w(3);
      scl_o = 1'b1;
      w(3);
      r = sda_i;
      scl_o = 1'b0;
   endtask : bit_io
   task automatic start();
      w(3);
      sda_oe_o = 1'b0;
      w(2);
      scl_o = 1'b1;
      w(3);
      sda_oe_o = 1'b1;
      w(3);
      scl_o = 1'b0;
   endtask : start
   task automatic stop();
      w(2);
      sda_oe_o = 1'b1;
      w(3);
      scl_o = 1'b1;
      w(3);
      sda_oe_o = 1'b0;
      w(3);
   endtask : stop
   // Lowers the clock with data left high, so no start is formed.
   task automatic hold_low();
      w(3);
      scl_o = 1'b0;
   endtask : hold_low
   task automatic put(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask : put
   task automatic get(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(~ack, r);
   endtask : get
endmodule : see_master
`default_nettype wire

// File: dv/see_props.sv
// Pin-level checker for the two-wire memory slave.
`timescale 1ns/1ns
`default_nettype none
module see_props (
   input wire logic core_clk_i, // Core clock.
   input wire logic rst_i, // Synchronous reset.
   input wire logic scl_i, // Serial clock.
   input wire logic sda_i, // Data wire.
   input wire logic select_pin_zero_i, // Chip select 0.
   input wire logic select_pin_one_i, // Chip select 1.
   input wire logic select_pin_two_i, // Chip select 2.
   input wire logic write_protect_input_i, // Write protect.
   input wire logic sda_o, // Drive value.
   input wire logic sda_oe_o // Drive enable.
);
   // ==========================================================
   // Bit counter since the last start, saturating at 15
   logic scl_reg, sda_reg, match;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] sel_reg, sel_next;
   always_comb begin
      cnt_next = cnt_reg;
      sel_next = sel_reg;
      if (scl_i && scl_reg && sda_reg && !sda_i) begin
         cnt_next = 4'h0;
      end else if (scl_i && !scl_reg && cnt_reg != 4'hf) begin
         cnt_next = cnt_reg + 4'h1;
         if (cnt_reg < 4'h8) begin
            sel_next = {sel_reg[6:0], sda_i};
         end
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cnt_reg <= 4'hf;
         sel_reg <= 8'h00;
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
      end else begin
         cnt_reg <= cnt_next;
         sel_reg <= sel_next;
         scl_reg <= scl_i;
         sda_reg <= sda_i;
      end
   end
   assign match = sel_reg[7:4] == see_pkg::SEE_TYPE_ID && sel_reg[3:1] ==
      {select_pin_two_i, select_pin_one_i, select_pin_zero_i};
   // ==========================================================
   // Assertions
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   a_drive_zero: assert property (sda_o == 1'b0)
      else $error("data drive value not low");
   a_quiet_reset: assert property ($fell(rst_i) |-> !sda_oe_o)
      else $error("driving after reset");
   a_edge_low: assert property (
      $changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 3))
      else $error("drive changed outside clock low");
   a_stop_idle: assert property (
      scl_i && $past(scl_i) && $rose(sda_i) |=> !sda_oe_o [*8])
      else $error("driving after stop");
   a_sel_silent: assert property (cnt_reg < 4'h8 |-> !sda_oe_o)
      else $error("driving during select byte");
   a_sel_ack: assert property (
      $fell(scl_i) && cnt_reg == 4'h9 && match |-> sda_oe_o)
      else $error("matching select not acked");
   a_sel_refuse: assert property (
      $fell(scl_i) && cnt_reg == 4'h9 && !match |-> !sda_oe_o)
      else $error("foreign select acked");
   a_refused_idle: assert property (cnt_reg > 4'h9 && !match |-> !sda_oe_o)
      else $error("driving after refused select");
   a_ack_span: assert property (
      $rose(sda_oe_o) && cnt_reg == 4'h8 |-> sda_oe_o [*8])
      else $error("select ack too short");
endmodule : see_props
bind see_slave see_props u_see_props (.core_clk_i(core_clk_i), .rst_i(rst_i),
   .scl_i(scl_i), .sda_i(sda_i), .select_pin_zero_i(select_pin_zero_i),
   .select_pin_one_i(select_pin_one_i), .select_pin_two_i(select_pin_two_i),
   .write_protect_input_i(write_protect_input_i), .sda_o(sda_o),
   .sda_oe_o(sda_oe_o));
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the two-wire memory slave.
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [2:0] pins = 3'h5;
   logic wp = 1'b0;
   logic scl, m_oe, d_oe, sda_w;
   int err_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   assign sda_w = ~(d_oe | m_oe);
   see_slave u_see_slave (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .scl_i(scl), .sda_i(sda_w), .select_pin_zero_i(pins[0]),
      .select_pin_one_i(pins[1]), .select_pin_two_i(pins[2]),
      .write_protect_input_i(wp), .sda_o(), .sda_oe_o(d_oe));
   see_master u_see_master (.clk_i(core_clk_i), .sda_i(sda_w),
      .scl_o(scl), .sda_oe_o(m_oe));
   initial begin
      forever #20 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         stop_test();
      end
   end
   // ==========================================================
   // Shared tasks
   function automatic logic [7:0] sel(input logic rd);
      return {see_pkg::SEE_TYPE_ID, pins, rd};
   endfunction : sel
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic open_w(input logic [15:0] ad);
      logic a;
      u_see_master.start();
      u_see_master.put(sel(1'b0), a);
      check({7'h00, a}, 8'h01);
      u_see_master.put(ad[15:8], a);
      check({7'h00, a}, 8'h01);
      u_see_master.put(ad[7:0], a);
      check({7'h00, a}, 8'h01);
   endtask : open_w
   task automatic write_at(input logic [15:0] ad, input logic [7:0] d0,
      input logic [7:0] d1);
      logic a;
      open_w(ad);
      u_see_master.put(d0, a);
      check({7'h00, a}, 8'h01);
      u_see_master.put(d1, a);
      check({7'h00, a}, 8'h01);
      u_see_master.stop();
   endtask : write_at
   task automatic read_at(input logic [15:0] ad, input logic [7:0] e0,
      input logic [7:0] e1);
      logic a;
      logic [7:0] d;
      open_w(ad);
      u_see_master.start();
      u_see_master.put(sel(1'b1), a);
      check({7'h00, a}, 8'h01);
      u_see_master.get(1'b1, d);
      check(d, e0);
      u_see_master.get(1'b0, d);
      check(d, e1);
      u_see_master.stop();
   endtask : read_at
   // ==========================================================
   // Scenarios
   task automatic t_wrap();
      write_at(16'hffff, 8'ha5, 8'h5a);
      read_at(16'hffff, 8'ha5, 8'h5a);
   endtask : t_wrap
   task automatic t_wp();
      logic a;
      write_at(16'h0100, 8'hc3, 8'h3c);
      wp = 1'b1;
      open_w(16'h0100);
      u_see_master.put(8'h00, a);
      check({7'h00, a}, 8'h00);
      u_see_master.stop();
      wp = 1'b0;
      read_at(16'h0100, 8'hc3, 8'h3c);
   endtask : t_wp
   task automatic t_refuse();
      logic a;
      logic [7:0] masks[4] = '{8'h10, 8'h08, 8'h04, 8'h02};
      for (int p = 0; p < 2; p++) begin
         pins = (p == 0) ? 3'h5 : 3'h2;
         foreach (masks[i]) begin
            u_see_master.start();
            u_see_master.put(sel(1'b0) ^ masks[i], a);
            check({7'h00, a}, 8'h00);
            u_see_master.put(sel(1'b0), a);
            check({7'h00, a}, 8'h00);
            u_see_master.stop();
         end
         open_w(16'h0002);
         u_see_master.stop();
      end
   endtask : t_refuse
   task automatic t_nostart();
      logic a;
      // The clock goes low first; otherwise a leading zero bit would fall
      // while the clock is high and form a start after all.
      u_see_master.hold_low();
      u_see_master.put(sel(1'b0), a);
      check({7'h00, a}, 8'h00);
      u_see_master.stop();
   endtask : t_nostart
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test
   initial begin
      repeat (6) @(negedge core_clk_i);
      rst_i = 1'b0;
      repeat (4) @(negedge core_clk_i);
      t_wrap();
      t_wp();
      t_refuse();
      t_nostart();
      stop_test();
   end
endmodule : tb
`default_nettype wire

// File: hw/see_line_mon.sv
// Pin synchroniser and start, stop and clock edge detector.
`timescale 1ns/1ns
`default_nettype none
module see_line_mon (
   input wire logic core_clk_i, // Core clock.
   input wire logic rst_i, // Synchronous reset, active high.
   input wire logic scl_i, // Serial clock pin level.
   input wire logic sda_i, // Serial data wire level.
   input wire logic [2:0] cs_i, // Chip select pins.
   input wire logic wp_i, // Write protect pin.
   see_evt_if.src evt // Events toward the core.
);
   localparam int unsigned N = see_pkg::SEE_PIN_COUNT;
   // Reset to the idle bus levels, clock and data high, so that the first
   // samples after reset are not taken for a clock edge or a bus condition.
   localparam logic [N-1:0] IDLE_LVL = {{(N-2){1'b0}}, 2'b11};
   // ==========================================================
   // Synchronisers
   logic [N-1:0] s1_reg, s1_next;
   logic [N-1:0] s2_reg, s2_next;
   logic [1:0] d_reg, d_next;
   always_comb begin
      s1_next = {wp_i, cs_i, sda_i, scl_i};
      s2_next = s1_reg;
      d_next = s2_reg[1:0];
   end
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         s1_reg <= IDLE_LVL;
         s2_reg <= IDLE_LVL;
         d_reg <= 2'h3;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         d_reg <= d_next;
      end
   end
   // ==========================================================
   // Events; only the second stage and later are looked at.
   assign evt.scl_rise = s2_reg[0] & ~d_reg[0];
   assign evt.scl_fall = ~s2_reg[0] & d_reg[0];
   assign evt.start = s2_reg[0] & d_reg[0] & ~s2_reg[1] & d_reg[1];
   assign evt.stop = s2_reg[0] & d_reg[0] & s2_reg[1] & ~d_reg[1];
   assign evt.sda = s2_reg[1];
   assign evt.cs = s2_reg[4:2];
   assign evt.wp = s2_reg[5];
endmodule : see_line_mon
`default_nettype wire

// File: hw/see_slave.sv
// Two-wire serial memory slave: protocol engine and byte array.
// Overview of operation
// - The array holds 2**ADDR_W bytes, 64 K by default or 32 K at 15 bits.
// - The block is only a slave and every step follows a serial clock edge, a start or a stop.
// - A start, then select code and direction bit, then an acknowledge.
// - Each byte written by the master is acknowledged in the ninth bit, except a foreign select code and data bytes under write protect.
// - Only a select code whose top four bits match the type id is served.
// - Select bits 3..1 must equal the three chip select pins.
// - With write protect high, data bytes get no ack and are not stored.
// - Traffic is ignored until a start, which is always watched for.
// - Data is sampled on serial clock rises and changed while it is low.
`timescale 1ns/1ns
`default_nettype none
module see_slave #(
   parameter int unsigned ADDR_W = see_pkg::SEE_ADDR_W_LARGE
) (
   input wire logic core_clk_i, // Core clock, 25 MHz.
   input wire logic rst_i, // Synchronous reset, active high.
   input wire logic scl_i, // Serial clock from the master.
   input wire logic sda_i, // Serial data wire level.
   input wire logic select_pin_zero_i, // Chip select pin 0.
   input wire logic select_pin_one_i, // Chip select pin 1.
   input wire logic select_pin_two_i, // Chip select pin 2.
   input wire logic write_protect_input_i, // High blocks array writes.
   output logic sda_o, // Serial data drive value, always low.
   output logic sda_oe_o // High while pulling serial data low.
);
   // ==========================================================
   // Line monitor
   // Floating select pins must be pulled low on the board side; the
   // logic simply reads whatever level arrives.
   see_evt_if evt ();
   see_line_mon u_mon (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .cs_i({select_pin_two_i, select_pin_one_i, select_pin_zero_i}),
      .wp_i(write_protect_input_i),
      .evt(evt)
   );
   // ==========================================================
   // Array
   logic [7:0] mem [0:(2**ADDR_W)-1];
   // ==========================================================
   // Protocol state
   see_pkg::see_state_t state_reg, state_next;
   see_pkg::see_phase_t phase_reg, phase_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic rw_reg, rw_next;
   logic mack_reg, mack_next;
   logic oe_reg, oe_next;
   logic sda_drv_reg;
   logic we;
   logic [7:0] rd_byte;
   logic [see_pkg::SEE_ADDR_BYTE_W-1:0] addr_wide;
   logic sel_match;
   assign rd_byte = mem[addr_reg];
   assign sel_match =
      (shift_reg[see_pkg::SEE_ID_MSB:see_pkg::SEE_ID_LSB]
       == see_pkg::SEE_TYPE_ID) &&
      (shift_reg[see_pkg::SEE_CS_MSB:see_pkg::SEE_CS_LSB]
       == evt.cs);
   always_comb begin
      state_next = state_reg;
      phase_next = phase_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      addr_next = addr_reg;
      rw_next = rw_reg;
      mack_next = mack_reg;
      oe_next = oe_reg;
      we = 1'b0;
      addr_wide = '0;
      addr_wide[ADDR_W-1:0] = addr_reg;
      if (evt.start) begin
         // A start re-arms the engine from any point of a transfer.
         state_next = see_pkg::SEE_ST_RX;
         phase_next = see_pkg::SEE_PH_SEL;
         cnt_next = 4'h0;
         oe_next = 1'b0;
      end else if (evt.stop) begin
         state_next = see_pkg::SEE_ST_IDLE;
         oe_next = 1'b0;
      end else begin
         case (state_reg)
            see_pkg::SEE_ST_IDLE: begin
               oe_next = 1'b0;
            end
            see_pkg::SEE_ST_RX: begin
               if (evt.scl_rise) begin
                  shift_next = {shift_reg[6:0], evt.sda};
                  cnt_next = cnt_reg + 4'h1;
               end else if (evt.scl_fall &&
                            cnt_reg == see_pkg::SEE_BITS_PER_BYTE) begin
                  state_next = see_pkg::SEE_ST_ACK;
                  oe_next = 1'b1;
                  case (phase_reg)
                     see_pkg::SEE_PH_SEL: begin
                        rw_next = shift_reg[see_pkg::SEE_RW_BIT];
                        if (!sel_match) begin
                           state_next = see_pkg::SEE_ST_IDLE;
                           oe_next = 1'b0;
                        end
                     end
                     see_pkg::SEE_PH_AHI: begin
                        addr_wide = {shift_reg, addr_wide[7:0]};
                        addr_next = addr_wide[ADDR_W-1:0];
                     end
                     see_pkg::SEE_PH_ALO: begin
                        addr_wide = {addr_wide[15:8], shift_reg};
                        addr_next = addr_wide[ADDR_W-1:0];
                     end
                     see_pkg::SEE_PH_DATA: begin
                        if (evt.wp) begin
                           // Refused byte: stay off the line until start.
                           state_next = see_pkg::SEE_ST_IDLE;
                           oe_next = 1'b0;
                        end else begin
                           we = 1'b1;
                           addr_next = addr_reg + 1'b1;
                        end
                     end
                     default: begin
                        state_next = see_pkg::SEE_ST_IDLE;
                     end
                  endcase
               end
            end
            see_pkg::SEE_ST_ACK: begin
               if (evt.scl_fall) begin
                  oe_next = 1'b0;
                  cnt_next = 4'h0;
                  if (phase_reg == see_pkg::SEE_PH_SEL && rw_reg) begin
                     state_next = see_pkg::SEE_ST_TX;
                     shift_next = rd_byte;
                     oe_next = ~rd_byte[7];
                     addr_next = addr_reg + 1'b1;
                  end else begin
                     state_next = see_pkg::SEE_ST_RX;
                     if (phase_reg != see_pkg::SEE_PH_DATA) begin
                        phase_next = see_pkg::see_phase_t'(phase_reg + 2'h1);
                     end
                  end
               end
            end
            see_pkg::SEE_ST_TX: begin
               if (evt.scl_fall) begin
                  if (cnt_reg == see_pkg::SEE_LAST_TX_BIT) begin
                     oe_next = 1'b0;
                     state_next = see_pkg::SEE_ST_MACK;
                  end else begin
                     shift_next = {shift_reg[6:0], 1'b0};
                     oe_next = ~shift_reg[6];
                     cnt_next = cnt_reg + 4'h1;
                  end
               end
            end
            see_pkg::SEE_ST_MACK: begin
               if (evt.scl_rise) begin
                  mack_next = ~evt.sda;
               end else if (evt.scl_fall) begin
                  cnt_next = 4'h0;
                  if (mack_reg) begin
                     state_next = see_pkg::SEE_ST_TX;
                     shift_next = rd_byte;
                     oe_next = ~rd_byte[7];
                     addr_next = addr_reg + 1'b1;
                  end else begin
                     state_next = see_pkg::SEE_ST_IDLE;
                  end
               end
            end
            default: begin
               state_next = see_pkg::SEE_ST_IDLE;
               oe_next = 1'b0;
            end
         endcase
      end
   end
   // ==========================================================
   // Registers; only serial clock edges, starts and stops move them, so the
   // engine never acts on its own.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_reg <= see_pkg::SEE_ST_IDLE;
         phase_reg <= see_pkg::SEE_PH_SEL;
         cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         addr_reg <= '0;
         rw_reg <= 1'b0;
         mack_reg <= 1'b0;
         oe_reg <= 1'b0;
         sda_drv_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         phase_reg <= phase_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         addr_reg <= addr_next;
         rw_reg <= rw_next;
         mack_reg <= mack_next;
         oe_reg <= oe_next;
         sda_drv_reg <= 1'b0;
      end
   end
   // The array has no reset; its content is retained state.
   always_ff @(posedge core_clk_i) begin
      if (we) begin
         mem[addr_reg] <= shift_reg;
      end
   end
   assign sda_o = sda_drv_reg;
   assign sda_oe_o = oe_reg;
endmodule : see_slave
`default_nettype wire

// File: shared/see_evt_if.sv
// Bus events passed from the line monitor to the slave core.
`timescale 1ns/1ns
`default_nettype none
interface see_evt_if;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   logic sda;
   logic [2:0] cs;
   logic wp;
   modport src (output scl_rise, scl_fall, start, stop, sda, cs, wp);
   modport dst (input scl_rise, scl_fall, start, stop, sda, cs, wp);
endinterface : see_evt_if
`default_nettype wire

// File: shared/see_pkg.sv
// Shared constants and types for the two-wire memory slave.
`default_nettype none
package see_pkg;
   // ==========================================================
   // Array geometry
   localparam int unsigned SEE_ADDR_W_LARGE = 16;
   localparam int unsigned SEE_ADDR_W_SMALL = 15;
   localparam int unsigned SEE_ADDR_BYTE_W = 16;
   // ==========================================================
   // Select code layout
   // Value is arbitrary; a real product puts its own type code here.
   localparam logic [3:0] SEE_TYPE_ID = 4'h6;
   localparam int unsigned SEE_ID_MSB = 7;
   localparam int unsigned SEE_ID_LSB = 4;
   localparam int unsigned SEE_CS_MSB = 3;
   localparam int unsigned SEE_CS_LSB = 1;
   localparam int unsigned SEE_RW_BIT = 0;
   // ==========================================================
   // Bit counting
   localparam logic [3:0] SEE_BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] SEE_LAST_TX_BIT = 4'h7;
   localparam int unsigned SEE_SYNC_STAGES = 2;
   localparam int unsigned SEE_PIN_COUNT = 6;
   // ==========================================================
   // States
   typedef enum logic [2:0] {
      SEE_ST_IDLE,
      SEE_ST_RX,
      SEE_ST_ACK,
      SEE_ST_TX,
      SEE_ST_MACK
   } see_state_t;
   typedef enum logic [1:0] {
      SEE_PH_SEL,
      SEE_PH_AHI,
      SEE_PH_ALO,
      SEE_PH_DATA
   } see_phase_t;
endpackage : see_pkg
`default_nettype wire
